/* File: common/usr_defs.svh */
// Timing, reset and channel constants for the ultrasonic command receiver
`ifndef USR_DEFS_SVH
`define USR_DEFS_SVH

// System clock
`define USR_CLK_HZ         50000000
`define USR_CLK_MHZ        50

// Time slot that paces the whole receive sequence
`define USR_SLOT_US        23100
`define USR_SLOT_CYC       (`USR_SLOT_US * `USR_CLK_MHZ)
`define USR_WAIT_US        46200
`define USR_WAIT_SLOTS     (`USR_WAIT_US / `USR_SLOT_US)
`define USR_REPEAT_US      184800
`define USR_REPEAT_SLOTS   (`USR_REPEAT_US / `USR_SLOT_US)
`define USR_RAMP_FIRST_US  115000
`define USR_RAMP_FIRST_SL  ((`USR_RAMP_FIRST_US + `USR_SLOT_US / 2) / `USR_SLOT_US)
`define USR_HOLD_US        700000
`define USR_HOLD_SLOTS     (`USR_HOLD_US / `USR_SLOT_US)

// Tone period limits, least rounds up and longest rounds down
`define USR_PER_MIN_US     18
`define USR_PER_MIN_CYC    (`USR_PER_MIN_US * `USR_CLK_MHZ)
`define USR_PER_MAX_US     36
`define USR_PER_MAX_CYC    (`USR_PER_MAX_US * `USR_CLK_MHZ)

// Least hold time of a local key and of the power pin force
`define USR_KEY_US         10
`define USR_KEY_CYC        (`USR_KEY_US * `USR_CLK_MHZ)
`define USR_FORCE_US       10
`define USR_FORCE_CYC      (`USR_FORCE_US * `USR_CLK_MHZ)

// Pulse width outputs
`define USR_PWM_HZ         8990
`define USR_PWM_STEPS      31
`define USR_PWM_UNIT_CYC   (`USR_CLK_HZ / (`USR_PWM_HZ * `USR_PWM_STEPS))
`define USR_DUTY1_RST      5'h10
`define USR_DUTY2_RST      5'h12
`define USR_DUTY3_RST      5'h0A
`define USR_DUTY_MAX       5'h1F

// Channel frequency plan in centi-hertz and acceptance in ppm
`define USR_NUM_CH         30
`define USR_F0_CHZ         3394489
`define USR_FSTEP_CHZ      34638
`define USR_TOL_LO_PPM     5100
`define USR_TOL_HI_PPM     3900

// Channel functions and bus code offset (bus value is channel plus one)
`define USR_CH_POWER       5'h01
`define USR_CH_MUTE        5'h02
`define USR_CH_A1_UP       5'h03
`define USR_CH_NORM        5'h04
`define USR_CH_A1_DN       5'h05
`define USR_CH_A2_UP       5'h07
`define USR_CH_A2_DN       5'h09
`define USR_CH_A3_UP       5'h0B
`define USR_CH_A3_DN       5'h0D
`define USR_CH_PROG_FIRST  5'h0F
`define USR_CH_PROG_LAST   5'h1E
`define USR_CODE_OFS       5'h01

`endif

/* File: common/usr_pkg.sv */
// Types shared by the ultrasonic command receiver
package usr_pkg;

  // Receive sequence states
  typedef enum logic [2:0] {
    usr_idle,
    usr_settle,
    usr_meas1,
    usr_meas2,
    usr_active
  } usr_state_e;

  // Channel number, zero meaning none
  typedef logic [4:0] usr_chan_t;

  // Mark count of an analog output, 0 to 31
  typedef logic [4:0] usr_duty_t;

endpackage

/* File: rtl/usr_pwm.sv */
// Pulse width generator for one analog output
`timescale 1ns/100ps
`include "usr_defs.svh"
module usr_pwm
  import usr_pkg::*;
#(
  parameter int unsigned UNIT_CYC = `USR_PWM_UNIT_CYC,
  parameter int unsigned STEPS    = `USR_PWM_STEPS
) (
  // Clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_sys_rst,
  // Setting
  input  wire usr_duty_t i_duty,
  input  wire logic      i_enable,
  // Output level
  output logic           o_pwm
);

  localparam int unsigned UW = $clog2(UNIT_CYC + 1);

  logic [UW-1:0] unit_r;
  logic [4:0]    phase_r;

  // Unit prescaler and phase within one repetition
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      unit_r  <= '0;
      phase_r <= '0;
    end else if (unit_r == UW'(UNIT_CYC - 1)) begin
      unit_r  <= '0;
      phase_r <= (phase_r == 5'(STEPS - 1)) ? 5'h00 : phase_r + 5'h01; // [RULE7]
    end else begin
      unit_r <= unit_r + UW'(1);
    end
  end

  // Mark while phase below setting; full setting never spaces
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pwm <= 1'b0;
    end else begin
      o_pwm <= i_enable && (phase_r < i_duty); // [RULE7]
    end
  end

endmodule

/* File: rtl/usr_receiver.sv */
// Ultrasonic remote command receiver with local keys and analog outputs
//
// Function
// [RULE1] Thirty channels shown as five-line binary code
// [RULE2] Settle one slot, then measure two slots
// [RULE3] Matching measures: wait two slots, pulse one
// [RULE4] Continuous tone repeats pulse every eight slots
// [RULE5] Bad tone period aborts back to start
// [RULE6] Accept frequency error 0.51 to 0.39 percent
// [RULE7] Analog outputs: 8.99 kHz, 31 steps
// [RULE8] Ramp step at 115 ms, then 184.8 ms
// [RULE9] Power-up settings 16, 18 and 10
// [RULE10] Normalize restores outputs one and two
// [RULE11] Mute toggles output three after 0.7 s
// [RULE12] Power toggles on command one held 0.7 s
// [RULE13] Power starts off after reset
// [RULE14] Power off freezes all analog settings; mute of output three still toggles while off
// [RULE15] Program channels only switch power on
// [RULE16] External pull on power pin latches on
// [RULE17] Local key held 10 us starts command
// [RULE18] Bus pins driven only during output pulse
// [RULE19] Local key beats remote tone
// [RULE20] Option: command one switches power off only
// [RULE21] Sixteen program, six ramp, three special channels
// [RULE22] Classify by counting against per-channel windows
// [RULE23] Bus code comes from channel table
`timescale 1ns/100ps
`include "usr_defs.svh"
module usr_receiver
  import usr_pkg::*;
#(
  parameter int unsigned SLOT_CYC     = `USR_SLOT_CYC,
  parameter bit          PWR_OFF_ONLY = 1'b0
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // Squared ultrasonic input
  input  wire logic       i_us_in,
  // Command bus pins, index 0..4 = lines A..E, active high
  input  wire logic [4:0] i_cmd_in,
  output logic [4:0]      o_cmd_out,
  output logic [4:0]      o_cmd_oe,
  // Power pin, driven while on
  input  wire logic       i_pwr_in,
  output logic            o_pwr_out,
  output logic            o_pwr_oe,
  // Analog pulse outputs
  output logic [2:0]      o_analog,
  // Status
  output usr_chan_t       o_chan,
  output logic            o_active
);

  localparam int unsigned SW       = $clog2(SLOT_CYC + 1);
  localparam logic [11:0] PER_MIN  = 12'(`USR_PER_MIN_CYC);
  localparam logic [11:0] PER_MAX  = 12'(`USR_PER_MAX_CYC);
  localparam logic [9:0]  KEY_CYC  = 10'(`USR_KEY_CYC);
  localparam logic [9:0]  FRC_CYC  = 10'(`USR_FORCE_CYC);
  localparam logic [3:0]  REP_SL   = 4'(`USR_REPEAT_SLOTS);
  localparam logic [3:0]  PH_START = 4'(`USR_REPEAT_SLOTS - `USR_WAIT_SLOTS);
  localparam logic [3:0]  RAMP_SL  = 4'(`USR_RAMP_FIRST_SL);
  localparam logic [5:0]  HOLD_SL  = 6'(`USR_HOLD_SLOTS);

  // Expected edge count of a channel over one slot
  function automatic int unsigned nom_cnt(input int k);
    longint unsigned f;
    f = longint'(`USR_F0_CHZ) + longint'(k) * longint'(`USR_FSTEP_CHZ);
    return 32'((f * longint'(SLOT_CYC)) / (longint'(`USR_CLK_HZ) * 64'd100));
  endfunction

  // Acceptance half width, narrowing linearly toward the top channel
  function automatic int unsigned tol_cnt(input int k);
    longint unsigned w;
    longint unsigned t;
    w = longint'(`USR_TOL_LO_PPM) * longint'(`USR_NUM_CH - 1 - k)
      + longint'(`USR_TOL_HI_PPM) * longint'(k);
    t = longint'(nom_cnt(k)) * w / (longint'(`USR_NUM_CH - 1) * 64'd1000000);
    return (t < 64'd1) ? 32'd1 : 32'(t);
  endfunction

  // Channel to pin pattern: value channel+1, E is bit 0, A..D bits 1..4
  function automatic logic [4:0] to_pins(input usr_chan_t ch);
    logic [4:0] n;
    n = ch + `USR_CODE_OFS;
    return {n[0], n[4], n[3], n[2], n[1]};
  endfunction

  // Pin pattern back to channel, zero for no valid key
  function automatic usr_chan_t from_pins(input logic [4:0] p);
    logic [4:0] n;
    n = {p[3], p[2], p[1], p[0], p[4]};
    return (n > `USR_CODE_OFS) ? n - `USR_CODE_OFS : 5'h00;
  endfunction

  usr_state_e    state_r;
  logic          src_local_r;
  usr_chan_t     chan_r;
  usr_chan_t     first_ch_r;
  usr_chan_t     cls;
  logic [SW-1:0] slot_cnt_r;
  logic          slot_tick;
  logic [3:0]    ph_r;
  logic [3:0]    rdly_r;
  logic [5:0]    elapsed_r;
  logic          us_m_r;
  logic          us_s_r;
  logic          us_d_r;
  logic          us_rise;
  logic [11:0]   per_cnt_r;
  logic [11:0]   gate_cnt_r;
  logic          remote_abort;
  logic [4:0]    key_m_r;
  logic [4:0]    key_s_r;
  logic [1:0]    drv_hist_r;
  logic          key_mask;
  usr_chan_t     key_ch;
  usr_chan_t     key_last_r;
  logic [9:0]    key_cnt_r;
  logic          local_start;
  logic          local_release;
  logic          sess_start;
  logic          drive;
  logic          step_ev;
  logic          hold_ev;
  logic          pwr_m_r;
  logic          pwr_s_r;
  logic [9:0]    frc_cnt_r;
  logic          force_ev;
  logic          pwr_on_r;
  logic          mute_r;
  usr_duty_t     duty_r [3];
  logic [4:0]    code_r;

  // Input synchronisers; first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      us_m_r  <= 1'b0;
      us_s_r  <= 1'b0;
      us_d_r  <= 1'b0;
      key_m_r <= '0;
      key_s_r <= '0;
      pwr_m_r <= 1'b0;
      pwr_s_r <= 1'b0;
    end else begin
      us_m_r  <= i_us_in;
      us_s_r  <= us_m_r;
      us_d_r  <= us_s_r;
      key_m_r <= i_cmd_in;
      key_s_r <= key_m_r;
      pwr_m_r <= i_pwr_in;
      pwr_s_r <= pwr_m_r;
    end
  end

  assign us_rise = us_s_r && !us_d_r;

  // Tone period watch: too short on an edge, too long without one
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      per_cnt_r <= '0;
    end else if (state_r == usr_idle || us_rise) begin
      per_cnt_r <= '0;
    end else if (per_cnt_r != 12'hFFF) begin
      per_cnt_r <= per_cnt_r + 12'h001;
    end
  end

  assign remote_abort = (state_r != usr_idle) && !src_local_r &&
                        ((us_rise && per_cnt_r < PER_MIN) || per_cnt_r > PER_MAX); // [RULE5]

  // Slot timer restarts with every new session
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      slot_cnt_r <= '0;
    end else if (state_r == usr_idle || sess_start || slot_tick) begin
      slot_cnt_r <= '0;
    end else begin
      slot_cnt_r <= slot_cnt_r + SW'(1);
    end
  end

  assign slot_tick = (slot_cnt_r == SW'(SLOT_CYC - 1));

  // Edge count over one measuring slot
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gate_cnt_r <= '0;
    end else if (slot_tick || (state_r != usr_meas1 && state_r != usr_meas2)) begin
      gate_cnt_r <= '0;
    end else if (us_rise && gate_cnt_r != 12'hFFF) begin
      gate_cnt_r <= gate_cnt_r + 12'h001;
    end
  end

  // Match the count against each channel window
  always_comb begin
    cls = '0;
    for (int k = 0; k < `USR_NUM_CH; k++) begin
      if (32'(gate_cnt_r) + tol_cnt(k) >= nom_cnt(k) &&
          32'(gate_cnt_r) <= nom_cnt(k) + tol_cnt(k)) begin // [RULE6] [RULE22]
        cls = usr_chan_t'(k + 1);
      end
    end
  end

  // Keys are unreadable while we drive, and two cycles after
  assign key_mask = drive || (drv_hist_r != 2'b00);
  assign key_ch   = from_pins(key_s_r);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      drv_hist_r <= '0;
    end else begin
      drv_hist_r <= {drv_hist_r[0], drive};
    end
  end

  // Key must stand unchanged for the least hold time
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      key_last_r <= '0;
      key_cnt_r  <= '0;
    end else if (!key_mask) begin
      key_last_r <= key_ch;
      if (key_ch == 5'h00 || key_ch != key_last_r) begin
        key_cnt_r <= '0;
      end else if (key_cnt_r != KEY_CYC) begin
        key_cnt_r <= key_cnt_r + 10'h001; // [RULE17]
      end
    end
  end

  // A fresh or changed key takes over any remote session
  assign local_start   = !key_mask && key_ch != 5'h00 && key_ch == key_last_r &&
                         key_cnt_r == KEY_CYC - 10'h001 &&
                         !(src_local_r && state_r == usr_active && chan_r == key_ch); // [RULE19]
  assign local_release = src_local_r && state_r == usr_active && !key_mask &&
                         key_ch != chan_r;
  assign sess_start    = local_start || (state_r == usr_idle && us_rise);

  // Receive sequence
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r     <= usr_idle;
      src_local_r <= 1'b0;
      chan_r      <= '0;
      first_ch_r  <= '0;
    end else if (local_start) begin
      state_r     <= usr_active; // [RULE17] [RULE19]
      src_local_r <= 1'b1;
      chan_r      <= key_ch;
    end else if (local_release || remote_abort) begin
      state_r     <= usr_idle; // [RULE5]
      src_local_r <= 1'b0;
    end else begin
      case (state_r)
        usr_idle: begin
          if (us_rise) begin
            state_r <= usr_settle; // [RULE2]
          end
        end
        usr_settle: begin
          if (slot_tick) begin
            state_r <= usr_meas1; // [RULE2]
          end
        end
        usr_meas1: begin
          if (slot_tick) begin
            first_ch_r <= cls;
            state_r    <= usr_meas2;
          end
        end
        usr_meas2: begin
          if (slot_tick) begin
            if (cls != 5'h00 && cls == first_ch_r) begin
              chan_r  <= cls; // [RULE3]
              state_r <= usr_active;
            end else begin
              state_r <= usr_idle;
            end
          end
        end
        usr_active: begin
          state_r <= usr_active;
        end
        default: begin
          state_r <= usr_idle;
        end
      endcase
    end
  end

  // Repeat phase: pulse slot comes two slots in, then every eight
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ph_r <= '0;
    end else if (local_start || (state_r == usr_meas2 && slot_tick)) begin
      ph_r <= PH_START; // [RULE3]
    end else if (state_r == usr_active && slot_tick) begin
      ph_r <= (ph_r == REP_SL - 4'h1) ? 4'h0 : ph_r + 4'h1; // [RULE4]
    end
  end

  assign drive = (state_r == usr_active) && (ph_r == 4'h0); // [RULE3] [RULE18]

  // Session age for ramp steps and held commands
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      elapsed_r <= '0;
      rdly_r    <= '0;
    end else if (sess_start) begin
      elapsed_r <= '0;
      rdly_r    <= RAMP_SL;
    end else if (slot_tick) begin
      if (elapsed_r != HOLD_SL) begin
        elapsed_r <= elapsed_r + 6'h01;
      end
      rdly_r <= (rdly_r == 4'h1) ? REP_SL : rdly_r - 4'h1; // [RULE8]
    end
  end

  // Events only count once the channel is known
  assign step_ev = (state_r == usr_active) && slot_tick && (rdly_r == 4'h1); // [RULE8]
  assign hold_ev = (state_r == usr_active) && slot_tick && (elapsed_r == HOLD_SL - 6'h01);

  // External force on the power pin, seen only while released
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      frc_cnt_r <= '0;
    end else if (pwr_on_r || !pwr_s_r) begin
      frc_cnt_r <= '0;
    end else if (frc_cnt_r != FRC_CYC) begin
      frc_cnt_r <= frc_cnt_r + 10'h001; // [RULE16]
    end
  end

  assign force_ev = !pwr_on_r && pwr_s_r && (frc_cnt_r == FRC_CYC - 10'h001);

  // Power state; the force wins over a same-cycle toggle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pwr_on_r <= 1'b0; // [RULE13]
    end else if (force_ev) begin
      pwr_on_r <= 1'b1; // [RULE16]
    end else if (hold_ev) begin
      if (chan_r == `USR_CH_POWER) begin
        pwr_on_r <= PWR_OFF_ONLY ? 1'b0 : !pwr_on_r; // [RULE12] [RULE20]
      end else if (chan_r >= `USR_CH_PROG_FIRST && chan_r <= `USR_CH_PROG_LAST) begin
        pwr_on_r <= 1'b1; // [RULE15]
      end
    end
  end

  // Mute of output three, toggled by a held command
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mute_r <= 1'b0;
    end else if (hold_ev && chan_r == `USR_CH_MUTE) begin
      mute_r <= !mute_r; // [RULE11]
    end
  end

  // Analog settings; frozen while power is off
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      duty_r[0] <= `USR_DUTY1_RST; // [RULE9]
      duty_r[1] <= `USR_DUTY2_RST;
      duty_r[2] <= `USR_DUTY3_RST;
    end else if (step_ev && pwr_on_r) begin // [RULE14]
      case (chan_r) // [RULE21]
        `USR_CH_A1_UP: if (duty_r[0] != `USR_DUTY_MAX) duty_r[0] <= duty_r[0] + 5'h01;
        `USR_CH_A1_DN: if (duty_r[0] != 5'h00) duty_r[0] <= duty_r[0] - 5'h01;
        `USR_CH_A2_UP: if (duty_r[1] != `USR_DUTY_MAX) duty_r[1] <= duty_r[1] + 5'h01;
        `USR_CH_A2_DN: if (duty_r[1] != 5'h00) duty_r[1] <= duty_r[1] - 5'h01;
        `USR_CH_A3_UP: if (duty_r[2] != `USR_DUTY_MAX) duty_r[2] <= duty_r[2] + 5'h01;
        `USR_CH_A3_DN: if (duty_r[2] != 5'h00) duty_r[2] <= duty_r[2] - 5'h01;
        `USR_CH_NORM: begin
          duty_r[0] <= `USR_DUTY1_RST; // [RULE10]
          duty_r[1] <= `USR_DUTY2_RST;
        end
        default: begin
          duty_r[0] <= duty_r[0];
        end
      endcase
    end
  end

  // One generator per analog output
  for (genvar g = 0; g < 3; g++) begin : g_pwm
    usr_pwm #(
      .UNIT_CYC (`USR_PWM_UNIT_CYC),
      .STEPS    (`USR_PWM_STEPS)
    ) u_pwm (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_duty    (duty_r[g]),
      .i_enable  ((g == 2) ? !mute_r : 1'b1), // [RULE11]
      .o_pwm     (o_analog[g]) // [RULE7]
    );
  end

  // Pin pattern of the current channel, held in a flop
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      code_r <= '0;
    end else begin
      code_r <= to_pins(chan_r); // [RULE1] [RULE23]
    end
  end

  // Lines float as inputs except in the pulse slot
  assign o_cmd_out = code_r;
  assign o_cmd_oe  = drive ? code_r : 5'h00; // [RULE18]
  assign o_pwr_out = pwr_on_r;
  assign o_pwr_oe  = pwr_on_r;
  assign o_chan    = chan_r;
  assign o_active  = (state_r == usr_active);

endmodule

/* File: bench/usr_receiver_monitor.sv */
// Port checker for the ultrasonic command receiver
`timescale 1ns/100ps
module usr_receiver_monitor
  import usr_pkg::*;
#(
  parameter int unsigned SLOT_CYC = 2000
) (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  // Pins
  input wire logic       i_us_in,
  input wire logic [4:0] i_cmd_in,
  input wire logic [4:0] o_cmd_oe,
  input wire logic       i_pwr_in,
  input wire logic       o_pwr_out,
  input wire logic       o_pwr_oe,
  // Status
  input wire usr_chan_t  o_chan,
  input wire logic       o_active
);
  logic [31:0] oe_len_r;
  logic [31:0] act_len_r;
  logic [11:0] gap_r;
  logic [9:0]  frc_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // Bus code of a channel, lines A..D carry N[1..4], E carries N[0]
  function automatic logic [4:0] code_of(input logic [4:0] ch);
    logic [4:0] n;
    n = ch + 5'h01;
    return {n[0], n[4], n[3], n[2], n[1]};
  endfunction

  // Length of the current drive pulse
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) oe_len_r <= '0;
    else oe_len_r <= (o_cmd_oe != 5'h00) ? oe_len_r + 1 : '0;
  end
  // Age of the session
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) act_len_r <= '0;
    else act_len_r <= o_active ? act_len_r + 1 : '0;
  end
  // Cycles since the last tone edge, saturating so a dead line never wraps
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) gap_r <= 12'hFFF;
    else if (i_us_in && !$past(i_us_in)) gap_r <= 12'h000;
    else if (gap_r != 12'hFFF) gap_r <= gap_r + 12'h001;
  end
  // Time the power pin has been held high
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) frc_r <= '0;
    else frc_r <= !i_pwr_in ? '0 : (frc_r == 10'h3FF) ? frc_r : frc_r + 10'h001;
  end

  chk_oe_in_session: assert property (o_cmd_oe != 5'h00 |-> o_active)
    else $error("bus driven outside a session");
  chk_oe_bus_code: assert property (o_cmd_oe != 5'h00
      |-> o_cmd_oe == code_of(o_chan))
    else $error("bus pattern does not match channel");
  chk_pulse_len: assert property ($fell(|o_cmd_oe) |-> oe_len_r == SLOT_CYC)
    else $error("drive pulse is not one slot long");
  chk_pulse_sched: assert property ($rose(|o_cmd_oe)
      |-> act_len_r + 4 >= 2 * SLOT_CYC
      && ((act_len_r + 4 - 2 * SLOT_CYC) % (8 * SLOT_CYC)) <= 8)
    else $error("drive pulse off its schedule");
  chk_short_abort: assert property ($rose(i_us_in) && gap_r < 12'd880
      && i_cmd_in == 5'h00 |-> ##[1:6] !o_active)
    else $error("short tone period did not abort");
  chk_long_abort: assert property (gap_r == 12'd1900 && i_cmd_in == 5'h00
      && $past(i_cmd_in, 8) == 5'h00 |-> !o_active)
    else $error("lost tone did not abort");
  chk_pwr_pin: assert property (o_pwr_oe == o_pwr_out)
    else $error("power pin drive differs from state");
  chk_pwr_force: assert property (frc_r == 10'd520 |-> o_pwr_out)
    else $error("forced power pin not latched on");
  chk_chan_range: assert property (o_active |-> o_chan >= 5'h01 && o_chan <= 5'h1E)
    else $error("session channel out of range");
endmodule

bind usr_receiver usr_receiver_monitor #(
  .SLOT_CYC (SLOT_CYC)
) u_mon (
  .i_clk     (i_clk),
  .i_sys_rst (i_sys_rst),
  .i_us_in   (i_us_in),
  .i_cmd_in  (i_cmd_in),
  .o_cmd_oe  (o_cmd_oe),
  .i_pwr_in  (i_pwr_in),
  .o_pwr_out (o_pwr_out),
  .o_pwr_oe  (o_pwr_oe),
  .o_chan    (o_chan),
  .o_active  (o_active)
);

/* File: bench/usr_far_side.sv */
// Remote tone source, local keys and pin wiring around the receiver
`timescale 1ns/100ps
module usr_far_side (
  // Clock
  input  wire logic        i_clk,
  // Bench controls
  input  wire logic        i_tone_en,
  input  wire logic [11:0] i_half,
  input  wire logic [4:0]  i_key,
  input  wire logic        i_force,
  // Receiver outputs
  input  wire logic [4:0]  i_cmd_out,
  input  wire logic [4:0]  i_cmd_oe,
  input  wire logic        i_pwr_out,
  input  wire logic        i_pwr_oe,
  // Wire levels
  output logic             o_us,
  output logic [4:0]       o_bus,
  output logic             o_pwr
);
  logic [11:0] ph_r   = 12'h000;
  logic        tone_r = 1'b0;

  // Tone stands low between bursts, half period set by the bench
  always_ff @(posedge i_clk) begin
    if (!i_tone_en) begin
      ph_r   <= 12'h000;
      tone_r <= 1'b0;
    end else if (ph_r + 12'h001 >= i_half) begin
      ph_r   <= 12'h000;
      tone_r <= ~tone_r;
    end else begin
      ph_r <= ph_r + 12'h001;
    end
  end
  assign o_us = tone_r;
  // Driven lines win, else the key, else the pull to idle
  assign o_bus = (i_cmd_oe & i_cmd_out) | (~i_cmd_oe & i_key);
  // Pin reads high while driven on or pulled up from outside
  assign o_pwr = (i_pwr_oe & i_pwr_out) | i_force;
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the ultrasonic command receiver
`timescale 1ns/100ps
module tb_top
  import usr_pkg::*;
;
  localparam int unsigned SLOT = 2000;
  localparam int unsigned UNIT = 179;

  logic        i_clk     = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        tone_en   = 1'b0;
  logic [11:0] half      = 12'h190;
  logic [4:0]  key       = 5'h00;
  logic        force_on  = 1'b0;
  logic        us;
  logic [4:0]  bus;
  logic        pwr_pin;
  logic [4:0]  cmd_out;
  logic [4:0]  cmd_oe;
  logic        pwr_out;
  logic        pwr_oe;
  logic [2:0]  analog;
  usr_chan_t   chan;
  logic        active;
  int          failures  = 0;
  int          checked   = 0;

  // Short slot keeps the run small; period limits stay below it
  usr_receiver #(
    .SLOT_CYC     (SLOT),
    .PWR_OFF_ONLY (1'b0)
  ) u_dut (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_us_in   (us),
    .i_cmd_in  (bus),
    .o_cmd_out (cmd_out),
    .o_cmd_oe  (cmd_oe),
    .i_pwr_in  (pwr_pin),
    .o_pwr_out (pwr_out),
    .o_pwr_oe  (pwr_oe),
    .o_analog  (analog),
    .o_chan    (chan),
    .o_active  (active)
  );

  usr_far_side u_far (
    .i_clk     (i_clk),
    .i_tone_en (tone_en),
    .i_half    (half),
    .i_key     (key),
    .i_force   (force_on),
    .i_cmd_out (cmd_out),
    .i_cmd_oe  (cmd_oe),
    .i_pwr_out (pwr_out),
    .i_pwr_oe  (pwr_oe),
    .o_us      (us),
    .o_bus     (bus),
    .o_pwr     (pwr_pin)
  );

  initial begin
    forever #10 i_clk = ~i_clk;
  end

  function automatic logic [4:0] code_of(input logic [4:0] ch);
    logic [4:0] n;
    n = ch + 5'h01;
    return {n[0], n[4], n[3], n[2], n[1]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Bounded wait, sampled just after each edge; 0 active, 1 idle, 2 drive, 3 no drive
  task automatic wait_for(input int kind, input int lim, output int n);
    n = 0;
    while (!((kind == 0 && active === 1'b1) || (kind == 1 && active === 1'b0)
        || (kind == 2 && cmd_oe !== 5'h00) || (kind == 3 && cmd_oe === 5'h00))) begin
      @(posedge i_clk);
      #1;
      n++;
      if (n > lim) begin
        failures++;
        $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, n, lim);
        test_done;
      end
    end
  endtask

  // One full period: high count is mark units times unit length
  task automatic t_pwm;
    int h0;
    int h1;
    int h2;
    h0 = 0;
    h1 = 0;
    h2 = 0;
    repeat (31 * UNIT) begin
      @(posedge i_clk);
      #1;
      h0 += (analog[0] === 1'b1);
      h1 += (analog[1] === 1'b1);
      h2 += (analog[2] === 1'b1);
    end
    check(h0, 16 * UNIT);
    check(h1, 18 * UNIT);
    check(h2, 10 * UNIT);
    $display("test pwm done");
  endtask

  // Local key held for hold cycles counted from acceptance
  task automatic t_key(input logic [4:0] ch, input int hold);
    int n;
    @(posedge i_clk);
    key <= code_of(ch);
    wait_for(0, 600, n);
    wait_for(2, 2 * SLOT + 10, n);
    check(n + 8 >= 2 * SLOT && n <= 2 * SLOT + 8, 1'b1);
    check(cmd_oe, code_of(ch));
    check(cmd_out, code_of(ch));
    check(chan, ch);
    wait_for(3, SLOT + 10, n);
    check(n, SLOT);
    repeat (hold - 3 * SLOT) @(posedge i_clk);
    key <= 5'h00;
    wait_for(1, 20, n);
    check(cmd_oe, 5'h00);
    $display("test key done");
  endtask

  // Tone with a period out of band never opens a session
  task automatic t_bad_tone(input logic [11:0] h);
    int hits;
    hits = 0;
    @(posedge i_clk);
    half    <= h;
    tone_en <= 1'b1;
    repeat (7 * SLOT / 2) begin
      @(posedge i_clk);
      #1;
      hits += (active !== 1'b0);
    end
    check(hits, 0);
    @(posedge i_clk);
    tone_en <= 1'b0;
    repeat (SLOT / 2) @(posedge i_clk);
    $display("test bad tone done");
  endtask

  // Outside pull on the power pin latches on
  task automatic t_force;
    @(posedge i_clk);
    force_on <= 1'b1;
    repeat (600) @(posedge i_clk);
    force_on <= 1'b0;
    repeat (10) @(posedge i_clk);
    #1;
    check(pwr_out, 1'b1);
    check(pwr_oe, 1'b1);
    $display("test force done");
  endtask

  // In-band tone opens a session; at this short slot all windows overlap, top wins
  task automatic t_remote;
    int n;
    @(posedge i_clk);
    half    <= 12'h2E0;
    tone_en <= 1'b1;
    wait_for(0, 4 * SLOT, n);
    check(n >= 3 * SLOT && n <= 3 * SLOT + 800, 1'b1);
    check(chan, 5'h1E);
    check(cmd_oe, 5'h00);
    @(posedge i_clk);
    tone_en <= 1'b0;
    wait_for(1, SLOT, n);
    check(n <= 1810, 1'b1);
    $display("test remote done");
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    check(cmd_oe, 5'h00);
    check(pwr_out, 1'b0);
    check(active, 1'b0);
    t_pwm();
    // Ramp key past its first step while off must leave settings alone
    t_key(5'h03, 11 * SLOT / 2);
    t_pwm();
    t_bad_tone(12'h190);
    t_bad_tone(12'h3E8);
    t_force();
    t_remote();
    // Power key held past the hold time toggles back off
    t_key(5'h01, 31 * SLOT);
    check(pwr_out, 1'b0);
    test_done();
  end
endmodule
